// *** pma_array.sv ***
/*
  Sum-of-products macrocell array with an APB register port for the connection map and cell setup.
  Assumes all pins and inputs are synchronous to CLK_SYS; clock inputs are sampled and edge detected.
*/
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "pma_defines.svh"

module pma_array
	import pma_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Dedicated inputs, bits 0 and 3 also serve as clocks
	input wire logic [`PMA_NUM_IN-1:0] DIN,
	// Macrocell I/O pins
	input wire logic [`PMA_NUM_MC-1:0] IO_IN,
	output logic [`PMA_NUM_MC-1:0] IO_OUT,
	output logic [`PMA_NUM_MC-1:0] IO_OE
);

	// ==========================================================
	// Constants and layout helpers
	localparam logic [`PMA_NUM_MC-1:0][4:0] PT_CNT = `PMA_PT_COUNTS;
	localparam pma_state_t ST_RST = '{
		fuse: {`PMA_NUM_TERMS{`PMA_FUSE_RST}},
		cfg: {`PMA_NUM_MC{`PMA_CFG_RST}},
		ff: 12'h000,
		clk_prev: 2'h0,
		io_out: 12'h000,
		io_oe: 12'h000,
		prdata: 32'h00000000,
		pready: 1'b0,
		pslverr: 1'b0
	};

	// First sum term of a cell
	function automatic int pt_base(input int c);
		int s;
		s = 0;
		for (int j = 0; j < c; j++) begin
			s = s + int'(PT_CNT[j]);
		end
		return s;
	endfunction

	pma_state_t st;
	pma_state_t next_st;

	logic [`PMA_NUM_SIG-1:0] sig;
	logic [`PMA_TERM_W-1:0] cols;
	logic [`PMA_NUM_TERMS-1:0] term_vec;
	logic [`PMA_NUM_TERMS-1:0] term_empty;
	logic [`PMA_NUM_MC-1:0] sum_vec;
	logic [`PMA_NUM_MC-1:0] edge_vec;
	logic [`PMA_NUM_MC-1:0] fb_vec;
	logic [`PMA_NUM_MC-1:0] data_vec;
	logic [`PMA_NUM_MC-1:0] pin_vec;
	logic [`PMA_NUM_MC-1:0] next_ff_vec;
	logic [`PMA_NUM_MC-1:0] byp_vec;
	logic [`PMA_NUM_MC-1:0] pol_vec;
	logic [`PMA_NUM_MC-1:0] swap_vec;
	logic [`PMA_NUM_MC-1:0] en_empty;
	logic edge1;
	logic edge2;
	logic sp_term;
	logic ar_term;

	// ==========================================================
	// Array columns: inputs then feedbacks, each true and inverted
	assign sig = {fb_vec, DIN};
	genvar k;
	generate
		for (k = 0; k < `PMA_NUM_SIG; k++) begin : g_col
			assign cols[2*k] = sig[k];
			assign cols[2*k+1] = ~sig[k];
		end
	endgenerate

	// ==========================================================
	// AND array, one term per row of the connection map
	genvar t;
	generate
		for (t = 0; t < `PMA_NUM_TERMS; t++) begin : g_term
			pma_term u_term (
				.cols(cols),
				.mask(st.fuse[t]),
				.term(term_vec[t])
			);
			assign term_empty[t] = ~|st.fuse[t];
		end
	endgenerate

	// Shared preset and reset rows
	assign sp_term = term_vec[`PMA_SP_TERM];
	assign ar_term = term_vec[`PMA_AR_TERM];

	// Rising edges of the two sampled clock inputs
	assign edge1 = DIN[`PMA_CLK1_IDX] & ~st.clk_prev[0];
	assign edge2 = DIN[`PMA_CLK2_IDX] & ~st.clk_prev[1];

	// ==========================================================
	// Macrocells
	genvar i;
	generate
		for (i = 0; i < `PMA_NUM_MC; i++) begin : g_cell
			localparam int B = pt_base(i);
			localparam int N = int'(PT_CNT[i]);
			assign byp_vec[i] = st.cfg[i].bypass_select_bit;
			assign pol_vec[i] = st.cfg[i].polarity_select_bit;
			assign swap_vec[i] = st.cfg[i].feedback_swap_bit;
			assign en_empty[i] = term_empty[`PMA_EN_BASE+i];
			// Fixed OR over this cell's own share of terms
			assign sum_vec[i] = |term_vec[B +: N];
			assign edge_vec[i] = st.cfg[i].clock_select_bit ? edge1 : edge2;
			// Reset row wins over preset and data
			assign next_ff_vec[i] = ar_term ? 1'b0 :
				(edge_vec[i] ? (sp_term | sum_vec[i]) : st.ff[i]);
			assign data_vec[i] = byp_vec[i] ? sum_vec[i] : st.ff[i];
			assign pin_vec[i] = pol_vec[i] ? data_vec[i] : ~data_vec[i];
			// Register feedback when swap agrees with registered mode
			assign fb_vec[i] = (swap_vec[i] ^ byp_vec[i]) ? st.ff[i] : IO_IN[i];
		end
	endgenerate

	// ==========================================================
	// Next state: cells, pins and the APB slave
	always_comb begin
		logic [31:0] rdata;
		logic hit;
		logic wr_ok;
		logic [7:0] ti;
		logic [3:0] ci;
		rdata = 32'h00000000;
		hit = 1'b0;
		wr_ok = 1'b0;
		ti = PADDR[10:3];
		ci = PADDR[5:2];
		next_st = st;
		next_st.clk_prev = {DIN[`PMA_CLK2_IDX], DIN[`PMA_CLK1_IDX]};
		next_st.ff = next_ff_vec;
		// Pins registered once so every output leaves a flip-flop
		next_st.io_out = pin_vec;
		next_st.io_oe = term_vec[`PMA_EN_BASE +: `PMA_NUM_MC];
		// Address decode
		if (PADDR < `PMA_FUSE_END) begin
			hit = 1'b1;
			wr_ok = 1'b1;
			rdata = PADDR[2] ? {12'h000, st.fuse[ti][51:32]} : st.fuse[ti][31:0];
		end else if (PADDR[11:6] == `PMA_CFG_PAGE && ci < 4'hC) begin
			hit = 1'b1;
			wr_ok = 1'b1;
			rdata = {28'h0000000, st.cfg[ci]};
		end else if (PADDR == `PMA_FF_ADDR) begin
			hit = 1'b1;
			rdata = {20'h00000, st.ff};
		end else if (PADDR == `PMA_PIN_ADDR) begin
			hit = 1'b1;
			rdata = {4'h0, st.io_oe, 4'h0, st.io_out};
		end else if (PADDR == `PMA_IN_ADDR) begin
			hit = 1'b1;
			rdata = {18'h00000, DIN};
		end
		// One wait state: answer is raised in the second access cycle
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (PSEL && PENABLE && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.prdata = PWRITE ? 32'h00000000 : rdata;
			next_st.pslverr = !hit || (PWRITE && !wr_ok);
		end
		// Write lands only on the edge that sees pready high
		if (PSEL && PENABLE && st.pready && PWRITE && hit && wr_ok) begin
			if (PADDR < `PMA_FUSE_END) begin
				if (PADDR[2]) begin
					next_st.fuse[ti][51:32] = PWDATA[19:0];
				end else begin
					next_st.fuse[ti][31:0] = PWDATA;
				end
			end else begin
				next_st.cfg[ci] = pma_cfg_t'(PWDATA[3:0]);
			end
		end
	end

	// ==========================================================
	// State register; reset leaves the map erased and flip-flops low
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	assign PRDATA = st.prdata;
	assign PREADY = st.pready;
	assign PSLVERR = st.pslverr;
	assign IO_OUT = st.io_out;
	assign IO_OE = st.io_oe;

	// ==========================================================
	// Checks
	// Checks sleep one edge past reset: the registered pins still hold reset values there
	logic chk_off;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			chk_off <= 1'b1;
		end else begin
			chk_off <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST || chk_off);

	AST_AR_CLEARS: assert property (ar_term |=> (st.ff == 12'h000))
		else $error("reset term did not clear flip-flops");

	AST_AR_OVER_SP: assert property ((ar_term && sp_term) |=> (st.ff == 12'h000) ##1
		((IO_OUT ^ ~$past(pol_vec)) & ~$past(byp_vec)) == 12'h000 || ar_term || sp_term)
		else $error("preset beat reset term");

	AST_SP_LOADS: assert property ((!ar_term && sp_term) |=>
		((st.ff & $past(edge_vec)) == $past(edge_vec)))
		else $error("preset did not load ones on clock edge");

	AST_SUM_CAPTURE: assert property ((!ar_term && !sp_term) |=>
		(((st.ff ^ $past(sum_vec)) & $past(edge_vec)) == 12'h000))
		else $error("flip-flop missed the OR sum");

	AST_HOLD_NO_EDGE: assert property (!ar_term |=>
		(((st.ff ^ $past(st.ff)) & ~$past(edge_vec)) == 12'h000))
		else $error("flip-flop changed without its clock edge");

	AST_REG_HIGH: assert property (1'b1 |=>
		(((IO_OUT ^ $past(st.ff)) & ~$past(byp_vec) & $past(pol_vec)) == 12'h000))
		else $error("registered active-high pin wrong");

	AST_REG_LOW: assert property (1'b1 |=>
		(((IO_OUT ^ ~$past(st.ff)) & ~$past(byp_vec) & ~$past(pol_vec)) == 12'h000))
		else $error("registered active-low pin wrong");

	AST_COMB_OUT: assert property (1'b1 |=>
		(((IO_OUT ^ $past(sum_vec)) & $past(byp_vec) & $past(pol_vec)) == 12'h000))
		else $error("combinatorial pin not the OR sum");

	AST_COMB_LOW: assert property (1'b1 |=>
		(((IO_OUT ^ ~$past(sum_vec)) & $past(byp_vec) & ~$past(pol_vec)) == 12'h000))
		else $error("combinatorial active-low pin not inverted");

	AST_EN_FREE: assert property (1'b1 |=> ((IO_OE | ~$past(en_empty)) == 12'hFFF))
		else $error("empty enable term did not drive pin");

	AST_TERM_EMPTY: assert property ((term_vec | ~term_empty) == {`PMA_NUM_TERMS{1'b1}})
		else $error("empty product term not high");

	AST_CFG_ERASED: assert property ($past(RST) |-> (st.cfg == {`PMA_NUM_MC{`PMA_CFG_RST}}))
		else $error("setup bits not erased after reset");

	AST_FB_REG: assert property ((((fb_vec ^ st.ff) & swap_vec & ~byp_vec) == 12'h000))
		else $error("registered cell lost register feedback");

	AST_FB_PIN: assert property ((((fb_vec ^ IO_IN) & ((swap_vec & byp_vec) | (~swap_vec & ~byp_vec))) == 12'h000))
		else $error("pin feedback not taken from the pin");

	AST_APB_WAIT: assert property ((PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
		else $error("APB answer not one wait state");

	COV_PRESET: cover property (sp_term && !ar_term && (edge_vec != 12'h000));
	COV_RESET: cover property (ar_term);
	COV_WRITE: cover property (PSEL && PENABLE && PREADY && PWRITE);
	COV_COMB_DRIVE: cover property (((byp_vec & pol_vec) != 12'h000) ##1 (IO_OE != 12'h000));
	COV_READ: cover property (PSEL && PENABLE && PREADY && !PWRITE);

endmodule

// *** pma_defines.svh ***
/*
  Constants of the macrocell array: sizes, product-term layout, register map and reset values.
  Assumes inclusion by bare name from the package and the array module.
*/
`ifndef PMA_DEFINES_SVH
`define PMA_DEFINES_SVH

// ==========================================================
// Array dimensions
`define PMA_NUM_IN 14
`define PMA_NUM_MC 12
`define PMA_NUM_SIG 26
`define PMA_TERM_W 52
`define PMA_NUM_TERMS 166
`define PMA_MAX_PT 16

// ==========================================================
// Product-term layout: sum terms per cell, then enables, preset, reset
`define PMA_PT_COUNTS {5'd8, 5'd10, 5'd12, 5'd14, 5'd16, 5'd16, 5'd16, 5'd16, 5'd14, 5'd12, 5'd10, 5'd8}
`define PMA_EN_BASE 152
`define PMA_SP_TERM 164
`define PMA_AR_TERM 165

// ==========================================================
// Clock inputs among the dedicated inputs
`define PMA_CLK1_IDX 0
`define PMA_CLK2_IDX 3

// ==========================================================
// Register map (byte addresses, 32-bit words)
`define PMA_FUSE_END 12'h530
`define PMA_CFG_PAGE 6'h18
`define PMA_FF_ADDR 12'h700
`define PMA_PIN_ADDR 12'h704
`define PMA_IN_ADDR 12'h708

// ==========================================================
// Reset values
`define PMA_FUSE_RST 52'h0
`define PMA_CFG_RST 4'hF

`endif

// *** pma_pkg.sv ***
/*
  Types of the macrocell array: macrocell configuration and the module state record.
  Assumes pma_defines.svh is on the include path.
*/
`include "pma_defines.svh"

package pma_pkg;

	// ==========================================================
	// Macrocell configuration, one nibble per cell
	typedef struct packed {
		logic feedback_swap_bit;
		logic clock_select_bit;
		logic bypass_select_bit;
		logic polarity_select_bit;
	} pma_cfg_t;

	// ==========================================================
	// Whole state of the array module
	typedef struct packed {
		logic [`PMA_NUM_TERMS-1:0][`PMA_TERM_W-1:0] fuse;
		pma_cfg_t [`PMA_NUM_MC-1:0] cfg;
		logic [`PMA_NUM_MC-1:0] ff;
		logic [1:0] clk_prev;
		logic [`PMA_NUM_MC-1:0] io_out;
		logic [`PMA_NUM_MC-1:0] io_oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pma_state_t;

endpackage

// *** pma_term.sv ***
/*
  One product term of the AND array.
  Assumes columns arrive as true/complement pairs and a mask bit of 1 means connected.
*/
`timescale 1ns/100ps
`include "pma_defines.svh"

module pma_term
	import pma_pkg::*;
(
	// Array columns and connection mask
	input wire logic [`PMA_TERM_W-1:0] cols,
	input wire logic [`PMA_TERM_W-1:0] mask,
	// Term result
	output logic term
);

	// ==========================================================
	// Wide AND; unconnected columns are forced high
	// An empty mask gives a high term; true and complement both connected gives low
	assign term = &(cols | ~mask);

endmodule

// *** pma_board.sv ***
/*
  Board model around the macrocell pins: resolves each pin level.
  Assumes the bench enables its driver only where the array driver is off.
*/
`timescale 1ns/100ps
`include "pma_defines.svh"

module pma_board
	import pma_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Array side
	input wire logic [`PMA_NUM_MC-1:0] io_out,
	input wire logic [`PMA_NUM_MC-1:0] io_oe,
	// Board driver
	input wire logic [`PMA_NUM_MC-1:0] drv_val,
	input wire logic [`PMA_NUM_MC-1:0] drv_en,
	// Resolved pin level
	output logic [`PMA_NUM_MC-1:0] io_in
);
	// ====================
	// Pin resolution
	logic [`PMA_NUM_MC-1:0] last;

	// Floating pins flip each cycle, so a stale level never passes
	always_comb begin
		for (int i = 0; i < `PMA_NUM_MC; i++) begin
			if (io_oe[i] && drv_en[i]) begin
				io_in[i] = 1'bx; // Contention
			end else if (io_oe[i]) begin
				io_in[i] = io_out[i];
			end else if (drv_en[i]) begin
				io_in[i] = drv_val[i];
			end else begin
				io_in[i] = ~last[i];
			end
		end
	end

	// Level of the previous cycle
	always_ff @(posedge clk_sys) begin
		last <= io_in;
	end
endmodule

// *** tb.sv ***
/*
  Self-checking bench of the macrocell array: APB setup, pin and flip-flop checks.
  Assumes the package, the array and the board model are compiled first.
*/
`timescale 1ns/100ps
`include "pma_defines.svh"

module tb
	import pma_pkg::*;
;
	// ====================
	// Signals
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [`PMA_NUM_IN-1:0] din = 14'h0000;
	logic [`PMA_NUM_MC-1:0] io_in, io_out, io_oe;
	logic [`PMA_NUM_MC-1:0] drv_val = 12'h000, drv_en = 12'h000;
	int n_errors = 0, compares = 0, cycles = 0;

	// ====================
	// Clock and hang guard
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end

	// Device and board
	pma_array u_dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.DIN(din), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe));
	pma_board u_board (.clk_sys(clk_sys), .io_out(io_out), .io_oe(io_oe), .drv_val(drv_val),
		.drv_en(drv_en), .io_in(io_in));

	// ====================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic set_term(input int t, input logic [31:0] lo);
		apb(1'b1, 12'(t * 8), lo);
	endtask

	task automatic cfg(input int i, input logic [3:0] v);
		apb(1'b1, 12'h600 + 12'(i * 4), {28'h0, v});
	endtask

	// Registered pins lag the inputs, so allow a few cycles
	task automatic settle();
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic pulse(input int idx);
		din[idx] <= 1'b1;
		settle();
		din[idx] <= 1'b0;
		settle();
	endtask

	// ====================
	// Scenarios
	task automatic t_reset();
		rd_chk(12'h600, 32'h0000000F);
		rd_chk(12'h62C, 32'h0000000F);
		rd_chk(12'h700, 32'h00000000);
		rd_chk(12'h704, 32'h0FFF0FFF);
		apb(1'b0, 12'h7FC, 32'h0);
		chk({31'h0, err}, 32'h1); // Unmapped word
		apb(1'b1, 12'h700, 32'hFFF);
		chk({31'h0, err}, 32'h1); // Read-only word
	endtask

	// Cell 0 and cell 11 follow DIN5; edges of the term ranges checked
	task automatic t_and();
		for (int t = 1; t < 8; t++) set_term(t, 32'h3);
		for (int t = 144; t < 151; t++) set_term(t, 32'h3);
		set_term(151, 32'h400);
		set_term(164, 32'h1000);
		set_term(165, 32'h4000);
		set_term(0, 32'h400);
		for (int v = 0; v < 2; v++) begin
			din[5] <= v[0];
			settle();
			chk({20'h0, io_out}, {20'h0, v[0], 10'h3FF, v[0]});
		end
		set_term(0, 32'h800);
		settle();
		chk({31'h0, io_out[0]}, 32'h0);
		set_term(0, 32'hC00);
		din[5] <= 1'b0;
		settle();
		chk({31'h0, io_out[0]}, 32'h0);
		set_term(0, 32'h400);
		rd_chk(12'h008, 32'h00000003);
		rd_chk(12'h00C, 32'h00000000);
	endtask

	task automatic t_pol();
		cfg(0, 4'hE);
		settle();
		chk({31'h0, io_out[0]}, 32'h1);
		din[5] <= 1'b1;
		settle();
		chk({31'h0, io_out[0]}, 32'h0);
	endtask

	// Registered cell on the first clock, then moved to the second
	task automatic t_reg();
		cfg(0, 4'hD);
		pulse(0);
		rd_chk(12'h700, 32'h00000FFF);
		din[5] <= 1'b0;
		settle();
		chk({31'h0, io_out[0]}, 32'h1);
		cfg(0, 4'h9);
		pulse(0);
		rd_chk(12'h700, 32'h000007FF);
		pulse(3);
		rd_chk(12'h700, 32'h000007FE);
		chk({31'h0, io_out[0]}, 32'h0);
	endtask

	// Preset from DIN6, reset from DIN7, cell 0 active low
	task automatic t_preset();
		cfg(0, 4'h8);
		din[6] <= 1'b1;
		pulse(3);
		pulse(0);
		rd_chk(12'h700, 32'h00000FFF);
		chk({31'h0, io_out[0]}, 32'h0);
		din[7] <= 1'b1;
		settle();
		rd_chk(12'h708, 32'h000000C0);
		rd_chk(12'h700, 32'h00000000);
		chk({31'h0, io_out[0]}, 32'h1);
		pulse(3);
		rd_chk(12'h700, 32'h00000000);
		din[6] <= 1'b0;
		din[7] <= 1'b0;
	endtask

	// Cell 1 as an input, then with register feedback
	task automatic t_fb();
		set_term(153, 32'h3);
		set_term(0, 32'h40000000);
		cfg(0, 4'hF);
		drv_en <= 12'h002;
		settle();
		chk({20'h0, io_oe}, 32'h00000FFD);
		chk({31'h0, io_out[0]}, 32'h0);
		drv_val <= 12'h002;
		settle();
		chk({31'h0, io_out[0]}, 32'h1);
		cfg(1, 4'h7);
		settle();
		chk({31'h0, io_out[0]}, 32'h0);
		pulse(0);
		drv_val <= 12'h000;
		settle();
		chk({31'h0, io_out[0]}, 32'h1);
	endtask

	// Mid-run reset with flip-flops set: everything must return to the erased state
	task automatic t_rerst();
		drv_en <= 12'h000;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(12'h700, 32'h00000000);
		rd_chk(12'h604, 32'h0000000F);
		rd_chk(12'h704, 32'h0FFF0FFF);
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_and();
		t_pol();
		t_reg();
		t_preset();
		t_fb();
		t_rerst();
		give_verdict();
	end
endmodule
